// ===== verilog/ascan_consts.svh
// Register offsets, field positions, reset values and clock rates for the scan controller
`ifndef ASCAN_CONSTS_SVH
`define ASCAN_CONSTS_SVH
`define ASCAN_OFF_CTRL 12'h000
`define ASCAN_OFF_SCAN_IVL 12'h004
`define ASCAN_OFF_SAMP_IVL 12'h008
`define ASCAN_OFF_SCANS 12'h00c
`define ASCAN_OFF_DELAY 12'h010
`define ASCAN_OFF_CHAN_EN 12'h014
`define ASCAN_OFF_STATUS 12'h018
`define ASCAN_OFF_CMD 12'h01c
`define ASCAN_CTRL_MODE_BIT 0
`define ASCAN_CTRL_RETRIG_BIT 1
`define ASCAN_CTRL_TSRC_LSB 2
`define ASCAN_CTRL_DSRC_LSB 4
`define ASCAN_CMD_SWTRIG_BIT 0
`define ASCAN_CMD_REARM_BIT 1
`define ASCAN_RST_SCAN_IVL 24'h000320
`define ASCAN_RST_SAMP_IVL 24'h000064
`define ASCAN_RST_SCANS 24'h000001
`define ASCAN_RST_DELAY 16'h0000
`define ASCAN_RST_CHAN_EN 8'h01
`define ASCAN_TIMEBASE_HZ 40000000
`define ASCAN_MCLK_HZ 50000000
`endif

// ===== verilog/ascan_pkg.sv
// Types shared by the scan controller files
package ascan_pkg;
	typedef enum logic [1:0] {
		ASCAN_TSRC_SW,
		ASCAN_TSRC_DIG,
		ASCAN_TSRC_ANA,
		ASCAN_TSRC_SYNC
	} ascan_tsrc_e;
	typedef enum logic [1:0] {
		ASCAN_DSRC_TB,
		ASCAN_DSRC_AUX1,
		ASCAN_DSRC_GTC0,
		ASCAN_DSRC_GTC1
	} ascan_dsrc_e;
	typedef logic [23:0] ascan_cnt_t;
endpackage : ascan_pkg

// ===== verilog/ascan_sync_edge.sv
// Two-stage synchroniser with rising-edge pulse for one pin input
`timescale 1ns/1ps
module ascan_sync_edge (
	input wire logic i_mclk,
	input wire logic i_nrst,
	input wire logic i_pin,
	output logic o_level,
	output logic o_rise
);
	logic s1_q, s1_d, s2_q, s2_d, s3_q, s3_d;

	// Next values; only s2 reads s1
	always_comb begin
		s1_d = i_pin;
		s2_d = s1_q;
		s3_d = s2_q;
	end

	// Registers
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end else begin
			s1_q <= s1_d;
			s2_q <= s2_d;
			s3_q <= s3_d;
		end
	end

	assign o_level = s2_q;
	assign o_rise = s2_q & ~s3_q;
endmodule : ascan_sync_edge

// ===== verilog/ascan_timebase.sv
// Fractional divider making 40 MHz timebase enable pulses from the system clock
`timescale 1ns/1ps
`include "ascan_consts.svh"
module ascan_timebase (
	input wire logic i_mclk,
	input wire logic i_nrst,
	output logic o_tick
);
	localparam int unsigned NUM = `ASCAN_TIMEBASE_HZ / 1000000;
	localparam int unsigned DEN = `ASCAN_MCLK_HZ / 1000000;
	logic [7:0] acc_q, acc_d;
	logic tick_q, tick_d;

	// Accumulate 40 per cycle, wrap at 50: four ticks in five cycles
	always_comb begin
		if (acc_q + 8'(NUM) >= 8'(DEN)) begin
			acc_d = acc_q + 8'(NUM) - 8'(DEN);
			tick_d = 1'b1;
		end else begin
			acc_d = acc_q + 8'(NUM);
			tick_d = 1'b0;
		end
	end

	// Registers
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			acc_q <= 8'h00;
			tick_q <= 1'b0;
		end else begin
			acc_q <= acc_d;
			tick_q <= tick_d;
		end
	end

	assign o_tick = tick_q;
endmodule : ascan_timebase

// ===== verilog/ascan_ctrl.sv
// Timed multi-channel scan controller with trigger modes and AXI4-Lite registers
// Overview of operation
// - 24-bit scan interval count spaces scan starts in timebase ticks.
// - 24-bit sample interval count spaces channel samples within a scan.
// - 24-bit count sets scans performed per accepted trigger.
// - 16-bit trigger delay count, in delay clock periods, before first scan.
// - Post-trigger mode scans at once and stops after programmed scans.
// - Delay mode counts delay clock rises down, scans when count hits zero.
// - Each accepted trigger yields enabled channels times scans samples.
// - Delay clock selectable: timebase, aux input 1, timer counter 0 or 1.
// - Retrigger enabled: each later trigger repeats the same burst.
// - Retrigger disabled: one trigger only until rearmed.
// - Triggers during a burst or its delay are ignored.
// - Every converted sample goes into the sample FIFO.
// - Stored samples are 14-bit two's complement.
// - Ascending channel list from enable mask, repeated each scan.
// - Trigger source selectable: software, digital, analog, system sync.
`timescale 1ns/1ps
`include "ascan_consts.svh"
module ascan_ctrl
	import ascan_pkg::*;
#(
	parameter int NCHAN = 8
) (
	input wire logic i_mclk,
	input wire logic i_nrst,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic i_dig_trig,
	input wire logic i_ana_trig,
	input wire logic i_system_sync_trigger,
	input wire logic i_aux_function_input_1,
	input wire logic i_general_timer_counter_0,
	input wire logic i_general_timer_counter_1,
	output logic o_conv_start,
	output logic [2:0] o_mux_chan,
	input wire logic i_conv_done,
	input wire logic [13:0] i_conv_data,
	output logic o_fifo_wr,
	output logic [13:0] o_fifo_data,
	input wire logic i_fifo_full,
	output logic o_active
);
	typedef enum logic [2:0] {ST_IDLE, ST_DELAY, ST_SAMPLE, ST_WAIT, ST_GAP} ascan_st_e;
	// Pin inputs all pass two flops first; only the rising edges are used
	logic [5:0] pin_rise;
	logic [5:0] pins;
	assign pins = {i_general_timer_counter_1, i_general_timer_counter_0, i_aux_function_input_1,
		i_system_sync_trigger, i_ana_trig, i_dig_trig};
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++) begin : g_sync
			ascan_sync_edge u_sync (
				.i_mclk(i_mclk),
				.i_nrst(i_nrst),
				.i_pin(pins[gi]),
				.o_level(),
				.o_rise(pin_rise[gi])
			);
		end
	endgenerate
	logic tb_tick;
	ascan_timebase u_tb (
		.i_mclk(i_mclk),
		.i_nrst(i_nrst),
		.o_tick(tb_tick)
	);
	// Configuration registers
	logic mode_q, mode_d, retrig_q, retrig_d;
	logic [1:0] tsrc_q, tsrc_d, dsrc_q, dsrc_d;
	ascan_cnt_t scan_ivl_q, scan_ivl_d, samp_ivl_q, samp_ivl_d, scans_q, scans_d;
	logic [15:0] delay_q, delay_d;
	logic [NCHAN-1:0] chan_en_q, chan_en_d;
	logic swtrig_q, swtrig_d, rearm_q, rearm_d;
	// AXI slave state
	logic awrdy_q, awrdy_d, wrdy_q, wrdy_d, bvalid_q, bvalid_d, arrdy_q, arrdy_d, rvalid_q, rvalid_d;
	logic aw_have_q, aw_have_d, w_have_q, w_have_d;
	logic [11:0] awaddr_q, awaddr_d;
	logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	// Bus slave: address and data taken in either order, response after both
	always_comb begin
		awrdy_d = ~aw_have_q & ~bvalid_q;
		wrdy_d = ~w_have_q & ~bvalid_q;
		aw_have_d = aw_have_q;
		w_have_d = w_have_q;
		awaddr_d = awaddr_q;
		wdata_d = wdata_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		mode_d = mode_q;
		retrig_d = retrig_q;
		tsrc_d = tsrc_q;
		dsrc_d = dsrc_q;
		scan_ivl_d = scan_ivl_q;
		samp_ivl_d = samp_ivl_q;
		scans_d = scans_q;
		delay_d = delay_q;
		chan_en_d = chan_en_q;
		swtrig_d = 1'b0;
		rearm_d = 1'b0;
		if (s_axi_awvalid && awrdy_q) begin
			aw_have_d = 1'b1;
			awaddr_d = s_axi_awaddr;
			awrdy_d = 1'b0;
		end
		if (s_axi_wvalid && wrdy_q) begin
			w_have_d = 1'b1;
			wdata_d = s_axi_wdata;
			wrdy_d = 1'b0;
		end
		if (bvalid_q && s_axi_bready) bvalid_d = 1'b0;
		if (aw_have_q && w_have_q && !bvalid_q) begin
			aw_have_d = 1'b0;
			w_have_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = 2'b00;
			// Full-word writes only; strobes are ignored
			case (awaddr_q)
				`ASCAN_OFF_CTRL: begin
					mode_d = wdata_q[`ASCAN_CTRL_MODE_BIT];
					retrig_d = wdata_q[`ASCAN_CTRL_RETRIG_BIT];
					tsrc_d = wdata_q[`ASCAN_CTRL_TSRC_LSB +: 2];
					dsrc_d = wdata_q[`ASCAN_CTRL_DSRC_LSB +: 2];
				end
				`ASCAN_OFF_SCAN_IVL: scan_ivl_d = wdata_q[23:0];
				`ASCAN_OFF_SAMP_IVL: samp_ivl_d = wdata_q[23:0];
				`ASCAN_OFF_SCANS: scans_d = wdata_q[23:0];
				`ASCAN_OFF_DELAY: delay_d = wdata_q[15:0];
				`ASCAN_OFF_CHAN_EN: chan_en_d = wdata_q[NCHAN-1:0];
				`ASCAN_OFF_CMD: begin
					swtrig_d = wdata_q[`ASCAN_CMD_SWTRIG_BIT];
					rearm_d = wdata_q[`ASCAN_CMD_REARM_BIT];
				end
				`ASCAN_OFF_STATUS: bresp_d = 2'b00;
				default: bresp_d = 2'b10;
			endcase
		end
	end
	// Scan engine state
	ascan_st_e st_q, st_d;
	ascan_cnt_t ivl_cnt_q, ivl_cnt_d, samp_cnt_q, samp_cnt_d, scan_left_q, scan_left_d;
	logic [15:0] dly_q, dly_d;
	logic [2:0] chan_q, chan_d;
	logic armed_q, armed_d, active_q, active_d, conv_q, conv_d, fwr_q, fwr_d;
	logic [13:0] fdata_q, fdata_d;
	logic ovf_q, ovf_d;
	logic trig_ev, dclk_rise, last_chan;
	logic [2:0] next_chan, first_en;
	// Selected trigger and delay-clock events
	always_comb begin
		case (tsrc_q)
			2'd0: trig_ev = swtrig_q;
			2'd1: trig_ev = pin_rise[0];
			2'd2: trig_ev = pin_rise[1];
			default: trig_ev = pin_rise[2];
		endcase
		case (dsrc_q)
			2'd0: dclk_rise = tb_tick;
			2'd1: dclk_rise = pin_rise[3];
			2'd2: dclk_rise = pin_rise[4];
			default: dclk_rise = pin_rise[5];
		endcase
	end
	// Next enabled channel above the current one, and the lowest enabled one
	always_comb begin
		next_chan = chan_q;
		last_chan = 1'b1;
		first_en = 3'd0;
		for (int k = NCHAN - 1; k >= 0; k--) begin
			if (chan_en_q[k] && 3'(k) > chan_q) begin
				next_chan = 3'(k);
				last_chan = 1'b0;
			end
			if (chan_en_q[k]) first_en = 3'(k);
		end
	end
	// Scan sequencer: delay in delay clock rises, scan interval and sample interval in timebase ticks
	always_comb begin
		st_d = st_q;
		ivl_cnt_d = ivl_cnt_q;
		samp_cnt_d = samp_cnt_q;
		scan_left_d = scan_left_q;
		dly_d = dly_q;
		chan_d = chan_q;
		armed_d = armed_q | rearm_q;
		active_d = active_q;
		conv_d = 1'b0;
		fwr_d = 1'b0;
		fdata_d = fdata_q;
		ovf_d = ovf_q;
		if (tb_tick && st_q != ST_IDLE && st_q != ST_DELAY) begin
			if (ivl_cnt_q != 24'h000000) ivl_cnt_d = ivl_cnt_q - 24'h000001;
			if (samp_cnt_q != 24'h000000) samp_cnt_d = samp_cnt_q - 24'h000001;
		end
		// Conversion result stored straight as two's complement
		if (i_conv_done) begin
			fwr_d = 1'b1;
			fdata_d = i_conv_data;
			ovf_d = ovf_q | i_fifo_full;
		end
		case (st_q)
			ST_IDLE: begin
				// Only armed idle engine accepts triggers
				if (trig_ev && armed_q && chan_en_q != '0 && scans_q != 24'h000000) begin
					// A rearm landing with the trigger keeps the engine armed
					armed_d = retrig_q | rearm_q;
					active_d = 1'b1;
					scan_left_d = scans_q;
					dly_d = delay_q;
					st_d = (mode_q && delay_q != 16'h0000) ? ST_DELAY : ST_SAMPLE;
					chan_d = first_en;
					ivl_cnt_d = scan_ivl_q;
					samp_cnt_d = samp_ivl_q;
				end
			end
			ST_DELAY: begin
				if (dclk_rise) begin
					dly_d = dly_q - 16'h0001;
					if (dly_q == 16'h0001) st_d = ST_SAMPLE;
				end
			end
			ST_SAMPLE: begin
				conv_d = 1'b1;
				samp_cnt_d = samp_ivl_q;
				st_d = ST_WAIT;
			end
			ST_WAIT: begin
				// Finish each conversion before moving on
				if (i_conv_done) begin
					if (!last_chan) begin
						chan_d = next_chan;
						st_d = ST_GAP;
					end else if (scan_left_q == 24'h000001) begin
						active_d = 1'b0;
						st_d = ST_IDLE;
					end else begin
						scan_left_d = scan_left_q - 24'h000001;
						chan_d = first_en;
						st_d = ST_GAP;
					end
				end
			end
			ST_GAP: begin
				// Gate next sample on sample spacing, and scan start on scan interval
				if (samp_cnt_q == 24'h000000 && (chan_q != first_en || ivl_cnt_q == 24'h000000)) begin
					st_d = ST_SAMPLE;
					if (chan_q == first_en) ivl_cnt_d = scan_ivl_q;
				end
			end
			default: st_d = ST_IDLE;
		endcase
	end
	// Read data mux
	always_comb begin
		arrdy_d = ~arrdy_q & ~rvalid_q & s_axi_arvalid;
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		if (rvalid_q && s_axi_rready) rvalid_d = 1'b0;
		if (s_axi_arvalid && arrdy_q) begin
			rvalid_d = 1'b1;
			rresp_d = 2'b00;
			rdata_d = 32'h00000000;
			case (s_axi_araddr)
				`ASCAN_OFF_CTRL: rdata_d = {26'h0, dsrc_q, tsrc_q, retrig_q, mode_q};
				`ASCAN_OFF_SCAN_IVL: rdata_d = {8'h00, scan_ivl_q};
				`ASCAN_OFF_SAMP_IVL: rdata_d = {8'h00, samp_ivl_q};
				`ASCAN_OFF_SCANS: rdata_d = {8'h00, scans_q};
				`ASCAN_OFF_DELAY: rdata_d = {16'h0000, delay_q};
				`ASCAN_OFF_CHAN_EN: rdata_d = 32'(chan_en_q);
				`ASCAN_OFF_STATUS: rdata_d = {28'h0, ovf_q, armed_q, st_q == ST_DELAY, active_q};
				`ASCAN_OFF_CMD: rdata_d = 32'h00000000;
				default: rresp_d = 2'b10;
			endcase
		end
	end
	// Registers
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			awrdy_q <= 1'b0; wrdy_q <= 1'b0; bvalid_q <= 1'b0; bresp_q <= 2'b00;
			aw_have_q <= 1'b0; w_have_q <= 1'b0; awaddr_q <= 12'h000; wdata_q <= 32'h0;
			arrdy_q <= 1'b0; rvalid_q <= 1'b0; rdata_q <= 32'h0; rresp_q <= 2'b00;
			mode_q <= 1'b0; retrig_q <= 1'b0; tsrc_q <= 2'b00; dsrc_q <= 2'b00;
			scan_ivl_q <= `ASCAN_RST_SCAN_IVL; samp_ivl_q <= `ASCAN_RST_SAMP_IVL;
			scans_q <= `ASCAN_RST_SCANS; delay_q <= `ASCAN_RST_DELAY;
			chan_en_q <= NCHAN'(`ASCAN_RST_CHAN_EN); swtrig_q <= 1'b0; rearm_q <= 1'b0;
			st_q <= ST_IDLE; ivl_cnt_q <= 24'h0; samp_cnt_q <= 24'h0; scan_left_q <= 24'h0;
			dly_q <= 16'h0; chan_q <= 3'h0; armed_q <= 1'b1; active_q <= 1'b0;
			conv_q <= 1'b0; fwr_q <= 1'b0; fdata_q <= 14'h0; ovf_q <= 1'b0;
		end else begin
			awrdy_q <= awrdy_d; wrdy_q <= wrdy_d; bvalid_q <= bvalid_d; bresp_q <= bresp_d;
			aw_have_q <= aw_have_d; w_have_q <= w_have_d; awaddr_q <= awaddr_d;
			wdata_q <= wdata_d; arrdy_q <= arrdy_d; rvalid_q <= rvalid_d;
			rdata_q <= rdata_d; rresp_q <= rresp_d;
			mode_q <= mode_d; retrig_q <= retrig_d; tsrc_q <= tsrc_d; dsrc_q <= dsrc_d;
			scan_ivl_q <= scan_ivl_d; samp_ivl_q <= samp_ivl_d; scans_q <= scans_d;
			delay_q <= delay_d; chan_en_q <= chan_en_d; swtrig_q <= swtrig_d; rearm_q <= rearm_d;
			st_q <= st_d; ivl_cnt_q <= ivl_cnt_d; samp_cnt_q <= samp_cnt_d;
			scan_left_q <= scan_left_d; dly_q <= dly_d; chan_q <= chan_d;
			armed_q <= armed_d; active_q <= active_d; conv_q <= conv_d;
			fwr_q <= fwr_d; fdata_q <= fdata_d; ovf_q <= ovf_d;
		end
	end
	// Outputs straight from flops
	assign s_axi_awready = awrdy_q;
	assign s_axi_wready = wrdy_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arrdy_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign o_conv_start = conv_q;
	assign o_mux_chan = chan_q;
	assign o_fifo_wr = fwr_q;
	assign o_fifo_data = fdata_q;
	assign o_active = active_q;
endmodule : ascan_ctrl

// ===== test/ascan_conv_model.sv
// Converter model answering each start with a channel-coded sample
`timescale 1ns/1ps
module ascan_conv_model #(
	parameter int LAT = 4
) (
	input wire logic i_mclk,
	input wire logic i_nrst,
	input wire logic i_conv_start,
	input wire logic [2:0] i_mux_chan,
	output logic o_conv_done,
	output logic [13:0] o_conv_data
);
	logic [2:0] cnt_q, cnt_d, chan_q, chan_d;
	logic [13:0] pat_q, pat_d;
	// Latch channel, count down conversion time
	always_comb begin
		cnt_d = cnt_q;
		chan_d = chan_q;
		pat_d = pat_q + 14'h0b35;
		if (i_conv_start) begin
			cnt_d = 3'(LAT);
			chan_d = i_mux_chan;
		end else if (cnt_q != 3'h0) begin
			cnt_d = cnt_q - 3'h1;
		end
	end
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			cnt_q <= 3'h0;
			chan_q <= 3'h0;
			pat_q <= 14'h0000;
		end else begin
			cnt_q <= cnt_d;
			chan_q <= chan_d;
			pat_q <= pat_d;
		end
	end
	// Junk outside the done pulse, so a late capture cannot pass
	assign o_conv_done = (cnt_q == 3'h1);
	assign o_conv_data = o_conv_done ? {1'b1, chan_q, 10'h15a} : pat_q;
endmodule : ascan_conv_model

// ===== test/ascan_ctrl_props.sv
// Concurrent checks on the scan controller ports
`timescale 1ns/1ps
module ascan_ctrl_props (
	input wire logic i_mclk,
	input wire logic i_nrst,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic o_conv_start,
	input wire logic [2:0] o_mux_chan,
	input wire logic i_conv_done,
	input wire logic [13:0] i_conv_data,
	input wire logic o_fifo_wr,
	input wire logic [13:0] o_fifo_data,
	input wire logic o_active
);
	logic [7:0] gap_q, gap_d;
	// Clocks since last start in this burst; idle counts as far apart
	always_comb begin
		gap_d = gap_q;
		if (o_conv_start) begin
			gap_d = 8'h00;
		end else if (!o_active) begin
			gap_d = 8'hff;
		end else if (gap_q != 8'hff) begin
			gap_d = gap_q + 8'h01;
		end
	end
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			gap_q <= 8'hff;
		end else begin
			gap_q <= gap_d;
		end
	end
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_nrst);
	// Channel select held for the two cycles after a start
	sequence s_mux_held;
		$stable(o_mux_chan) [*2];
	endsequence
	// Active falls in the cycle the last write stands
	sequence s_wrote_lately;
		o_fifo_wr;
	endsequence
	property p_fifo_follows_done;
		i_conv_done |=> o_fifo_wr && (o_fifo_data == $past(i_conv_data));
	endproperty
	a_fifo_follows_done: assert property (p_fifo_follows_done)
		else $error("sample not stored unchanged after conversion");
	property p_fifo_has_cause;
		o_fifo_wr |-> $past(i_conv_done);
	endproperty
	a_fifo_has_cause: assert property (p_fifo_has_cause)
		else $error("fifo write without a conversion");
	property p_conv_in_burst;
		o_conv_start |-> o_active;
	endproperty
	a_conv_in_burst: assert property (p_conv_in_burst)
		else $error("conversion started while not active");
	// 100 timebase ticks at 4 per 5 clocks, small margin for phase
	property p_sample_gap;
		o_conv_start |-> gap_q >= 8'd118;
	endproperty
	a_sample_gap: assert property (p_sample_gap)
		else $error("conversions closer than the sample interval");
	property p_mux_steady;
		o_conv_start |=> s_mux_held;
	endproperty
	a_mux_steady: assert property (p_mux_steady)
		else $error("channel select moved during conversion");
	property p_active_ends;
		$fell(o_active) |-> s_wrote_lately;
	endproperty
	a_active_ends: assert property (p_active_ends)
		else $error("active dropped without a final sample");
	property p_read_answer;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_read_answer: assert property (p_read_answer)
		else $error("read data not one cycle after address");
	property p_arready_pulse;
		s_axi_arready |=> !s_axi_arready;
	endproperty
	a_arready_pulse: assert property (p_arready_pulse)
		else $error("read address ready longer than one cycle");
endmodule : ascan_ctrl_props

bind ascan_ctrl ascan_ctrl_props ascan_ctrl_props_inst (.i_mclk, .i_nrst, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .o_conv_start, .o_mux_chan, .i_conv_done, .i_conv_data,
	.o_fifo_wr, .o_fifo_data, .o_active);

// ===== test/ascan_ctrl_tb_top.sv
// Bench for the scan controller: registers, triggers, delay and bursts
`timescale 1ns/1ps
`include "ascan_consts.svh"
module ascan_ctrl_tb_top;
	logic i_mclk, i_nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [2:0] tpin, dpin, o_mux_chan;
	logic o_conv_start, i_conv_done, o_fifo_wr, i_fifo_full, o_active;
	logic [13:0] i_conv_data, o_fifo_data;
	logic [13:0] got [0:255];
	int n_wr = 0;
	int err_total, comparisons, base;
	logic [11:0] raddr [5] = '{`ASCAN_OFF_SCAN_IVL, `ASCAN_OFF_SAMP_IVL, `ASCAN_OFF_SCANS,
		`ASCAN_OFF_DELAY, `ASCAN_OFF_CHAN_EN};
	logic [31:0] rexp [5] = '{32'(`ASCAN_RST_SCAN_IVL), 32'(`ASCAN_RST_SAMP_IVL),
		32'(`ASCAN_RST_SCANS), 32'(`ASCAN_RST_DELAY), 32'(`ASCAN_RST_CHAN_EN)};
	ascan_ctrl #(.NCHAN(8)) ascan_ctrl_inst (.i_mclk, .i_nrst, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .i_dig_trig(tpin[0]), .i_ana_trig(tpin[1]),
		.i_system_sync_trigger(tpin[2]), .i_aux_function_input_1(dpin[0]),
		.i_general_timer_counter_0(dpin[1]), .i_general_timer_counter_1(dpin[2]), .o_conv_start,
		.o_mux_chan, .i_conv_done, .i_conv_data, .o_fifo_wr, .o_fifo_data, .i_fifo_full, .o_active);
	ascan_conv_model #(.LAT(4)) ascan_conv_model_inst (.i_mclk, .i_nrst,
		.i_conv_start(o_conv_start), .i_mux_chan(o_mux_chan), .o_conv_done(i_conv_done),
		.o_conv_data(i_conv_data));
	// Clock, 20 ns period
	always #10 i_mclk = ~i_mclk;
	// Sample sink standing in for the fifo
	always @(posedge i_mclk) begin
		if (o_fifo_wr === 1'b1) begin
			got[n_wr[7:0]] <= o_fifo_data;
			n_wr <= n_wr + 1;
		end
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// Address and data offered together, each dropped when taken
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge i_mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge i_mclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axi_wr
	task automatic axi_rd(input logic [11:0] a);
		@(posedge i_mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge i_mclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axi_rd
	// Source 0 is the software command, others a trigger pin
	task automatic fire(input int src);
		base = n_wr;
		if (src == 0) begin
			axi_wr(`ASCAN_OFF_CMD, 32'h1);
		end else begin
			@(posedge i_mclk);
			tpin[src - 1] <= 1'b1;
			repeat (4) @(posedge i_mclk);
			tpin[src - 1] <= 1'b0;
		end
	endtask : fire
	task automatic pulse_d(input int s, input int n);
		repeat (n) begin
			@(posedge i_mclk);
			dpin[s] <= 1'b1;
			repeat (3) @(posedge i_mclk);
			dpin[s] <= 1'b0;
			repeat (3) @(posedge i_mclk);
		end
	endtask : pulse_d
	// Wait for the burst to end, then check count and ascending channel order
	task automatic burst_chk(input int n, input logic [7:0] m);
		int c;
		c = 0;
		repeat (8) @(posedge i_mclk);
		while (o_active === 1'b1) @(posedge i_mclk);
		repeat (4) @(posedge i_mclk);
		chk("sample count", 32'(n), 32'(n_wr - base));
		for (int k = base; k < n_wr; k++) begin
			while (!m[c]) c = (c + 1) % 8;
			chk("sample", {18'h0, 1'b1, 3'(c), 10'h15a}, {18'h0, got[k]});
			c = (c + 1) % 8;
		end
	endtask : burst_chk
	task automatic report_and_stop();
		if (err_total == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : report_and_stop
	// Watchdog well beyond the expected run
	initial begin
		repeat (60000) @(posedge i_mclk);
		err_total++;
		report_and_stop();
	end
	initial begin
		{i_mclk, i_nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
		{s_axi_rready, tpin, dpin, i_fifo_full, err_total, comparisons} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
		repeat (2) @(posedge i_mclk);
		i_nrst <= 1'b1;
		repeat (2) @(posedge i_mclk);
		for (int i = 0; i < 5; i++) begin
			axi_rd(raddr[i]);
			chk("reset value", rexp[i], rd);
		end
		axi_rd(12'h020);
		chk("unmapped resp", 32'h2, {30'h0, rsp});
		axi_wr(12'h020, 32'h0);
		chk("unmapped wr resp", 32'h2, {30'h0, rsp});
		axi_wr(`ASCAN_OFF_STATUS, 32'hf);
		chk("status wr resp", 32'h0, {30'h0, rsp});
		axi_wr(`ASCAN_OFF_DELAY, 32'hffffffff);
		chk("write resp", 32'h0, {30'h0, rsp});
		axi_rd(`ASCAN_OFF_DELAY);
		chk("delay width", 32'h0000ffff, rd);
		axi_wr(`ASCAN_OFF_SAMP_IVL, 32'h64);
		axi_wr(`ASCAN_OFF_SCAN_IVL, 32'h190);
		axi_wr(`ASCAN_OFF_SCANS, 32'h2);
		axi_wr(`ASCAN_OFF_CHAN_EN, 32'ha5);
		axi_wr(`ASCAN_OFF_CTRL, 32'h2);
		axi_rd(`ASCAN_OFF_CTRL);
		chk("ctrl", 32'h2, rd);
		// Post trigger, second trigger mid-burst must be ignored
		fire(0);
		repeat (200) @(posedge i_mclk);
		axi_wr(`ASCAN_OFF_CMD, 32'h1);
		axi_rd(`ASCAN_OFF_STATUS);
		chk("active flag", 32'h1, rd & 32'h1);
		burst_chk(8, 8'ha5);
		for (int s = 1; s < 4; s++) begin
			axi_wr(`ASCAN_OFF_CTRL, 32'h2 | (32'(s) << 2));
			fire(s);
			burst_chk(8, 8'ha5);
		end
		// Delay of 3 from each delay clock; pins stand still until pulsed
		axi_wr(`ASCAN_OFF_SCANS, 32'h1);
		axi_wr(`ASCAN_OFF_CHAN_EN, 32'h81);
		axi_wr(`ASCAN_OFF_DELAY, 32'h3);
		for (int s = 0; s < 4; s++) begin
			axi_wr(`ASCAN_OFF_CTRL, 32'h3 | (32'(s) << 4));
			fire(0);
			if (s > 0) begin
				repeat (300) @(posedge i_mclk);
				axi_rd(`ASCAN_OFF_STATUS);
				chk("delay phase", 32'h2, rd & 32'h2);
				pulse_d(s - 1, 2);
				repeat (30) @(posedge i_mclk);
				chk("early samples", 32'h0, 32'(n_wr - base));
				pulse_d(s - 1, 1);
			end
			burst_chk(2, 8'h81);
		end
		// Single trigger, ignored repeat, rearm; overflow flag sticks
		axi_wr(`ASCAN_OFF_CTRL, 32'h0);
		axi_wr(`ASCAN_OFF_CMD, 32'h2);
		i_fifo_full <= 1'b1;
		fire(0);
		burst_chk(2, 8'h81);
		i_fifo_full <= 1'b0;
		fire(0);
		burst_chk(0, 8'h81);
		axi_rd(`ASCAN_OFF_STATUS);
		chk("overflow flag", 32'h8, rd & 32'h8);
		axi_wr(`ASCAN_OFF_CMD, 32'h2);
		fire(0);
		burst_chk(2, 8'h81);
		report_and_stop();
	end
endmodule : ascan_ctrl_tb_top
